/* File: mfr_axil_slave.sv */
`include "mfr_cfg.svh"
`default_nettype none

module mfr_axil_slave
    import mfr_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write channels
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // Read channels
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Register access
    mfr_reg_if.slave         rb
);

    logic        aw_held_r;
    logic        w_held_r;
    logic        ar_held_r;
    logic [7:0]  awaddr_r;
    logic [7:0]  araddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_go;
    logic        rd_go;

    assign wr_go      = aw_held_r && w_held_r && !bvalid;
    assign rd_go      = ar_held_r && !rvalid;
    assign rb.wr_req  = wr_go;
    assign rb.wr_idx  = awaddr_r[7:2];
    assign rb.wr_data = wdata_r;
    assign rb.wr_strb = wstrb_r;
    assign rb.rd_req  = rd_go;
    assign rb.rd_idx  = araddr_r[7:2];

    // ----------------------------------------------------------------
    // Write address and data, taken in either order
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awready   <= 1'b0;
            awaddr_r  <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            awready   <= 1'b0;
            awaddr_r  <= awaddr;
        end else begin
            if (wr_go)
                aw_held_r <= 1'b0;
            awready <= !aw_held_r && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wready   <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_r <= 1'b1;
            wready   <= 1'b0;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
        end else begin
            if (wr_go)
                w_held_r <= 1'b0;
            wready <= !w_held_r && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `MFR_RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= rb.wr_hit ? `MFR_RESP_OKAY : `MFR_RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held_r <= 1'b0;
            arready   <= 1'b0;
            araddr_r  <= 8'h00;
        end else if (arvalid && arready) begin
            ar_held_r <= 1'b1;
            arready   <= 1'b0;
            araddr_r  <= araddr;
        end else begin
            if (rd_go)
                ar_held_r <= 1'b0;
            arready <= !ar_held_r && !rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `MFR_RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= {16'h0000, rb.rd_data};
            rresp  <= rb.rd_hit ? `MFR_RESP_OKAY : `MFR_RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: mfr_cfg.svh */
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MFR_IDX_IRQ_EN      6'h12
`define MFR_IDX_STATUS      6'h13
`define MFR_IDX_CTRL2       6'h15
`define MFR_IDX_SOFT        6'h1F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MFR_B_FIFO_ERR      7
`define MFR_B_IDLE_INS      3
`define MFR_B_IDLE_DEL      2
`define MFR_B_LINE_LB       14
`define MFR_B_SPD_LSB       13
`define MFR_B_SPD_MSB       6
`define MFR_B_RX_TIM        5
`define MFR_B_TX_TIM        4
`define MFR_B_BCE           3
`define MFR_B_SW_RST        0

// ----------------------------------------------------------------
// Reset and fixed read values
// ----------------------------------------------------------------
`define MFR_RST_IRQ_EN      3'h0
`define MFR_RST_STATUS      3'h0
`define MFR_RST_SPEED       2'h2
`define MFR_RST_RX_TIM      1'h1
`define MFR_RST_TX_TIM      1'h1
`define MFR_RST_BCE         1'h0
`define MFR_RST_LINE_LB     1'h0
`define MFR_CTRL2_RSV_HI    6'h20
`define MFR_CTRL2_RSV_LO    3'h6
`define MFR_RESP_OKAY       2'h0
`define MFR_RESP_DECERR     2'h3

`endif

/* File: mfr_evt_latch.sv */
`include "mfr_cfg.svh"
`default_nettype none

module mfr_evt_latch
    import mfr_pkg::*;
(
    // Clock and reset
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire logic     sw_rst,
    // Events and read clear
    input  wire mfr_evt_t evt,
    input  wire logic     rd_clr,
    // Latched status
    output mfr_evt_t      status
);

    // ----------------------------------------------------------------
    // Latching-high bits; a live event wins over any clear
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            status <= `MFR_RST_STATUS;
        else
            status <= evt | ((rd_clr || sw_rst) ? 3'h0 : status);
    end

    a_ovf_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        evt[2] |=> status[2])
        else $error("fifo error event not latched");
    a_ins_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        evt[1] |=> status[1])
        else $error("idle inserted event not latched");
    a_del_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        evt[0] |=> status[0])
        else $error("idle deleted event not latched");
    a_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_rst && evt == 3'h0 |=> status == 3'h0)
        else $error("status not cleared by software reset");
    a_hold_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        !rd_clr && !sw_rst |=> (status & $past(status)) == $past(status))
        else $error("latched status lost without a read");
    a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_clr |=> status == $past(evt))
        else $error("read did not clear latched status");

endmodule

`default_nettype wire

/* File: mfr_fifo_peer.sv */
`default_nettype none
module mfr_fifo_peer (
    // Clock
    input  wire logic       aclk,
    // Request from bench
    input  wire logic [2:0] req,
    // Event strobes
    output logic            ovf,
    output logic            ins,
    output logic            del
);
    timeunit 1ns;
    timeprecision 100ps;
    // Copper FIFO event strobes repeat the bench request, registered one cycle later
    always_ff @(posedge aclk) begin
        {ovf, ins, del} <= req;
    end
endmodule
`default_nettype wire

/* File: mfr_mac_regs.sv */
`include "mfr_cfg.svh"
`default_nettype none

module mfr_mac_regs
    import mfr_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Copper FIFO events
    input  wire logic        fifo_ovf_evt,
    input  wire logic        fifo_idle_ins_evt,
    input  wire logic        fifo_idle_del_evt,
    // Link state
    input  wire logic        link_up,
    input  wire logic [1:0]  link_speed,
    input  wire logic        mac_loopback,
    // Data path controls
    output logic             line_loopback,
    output logic [1:0]       mac_speed,
    output logic             rx_clk_centre,
    output logic             tx_clk_delay,
    output logic             block_carrier_ext,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx == `MFR_IDX_IRQ_EN) || (idx == `MFR_IDX_STATUS) ||
                     (idx == `MFR_IDX_CTRL2)  || (idx == `MFR_IDX_SOFT);
    endfunction

    // New value of one bit under the byte strobes
    function automatic logic wbit(input logic [31:0] data,
                                  input logic [3:0]  strb,
                                  input int          pos,
                                  input logic        old);
        wbit = strb[pos / 8] ? data[pos] : old;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    mfr_reg_if rb ();

    mfr_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .awaddr  (s_axi_awaddr),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .bresp   (s_axi_bresp),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .araddr  (s_axi_araddr),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rb      (rb)
    );

    logic        wr_en_irq;
    logic        wr_ctrl2;
    logic        wr_soft;
    logic        rd_status;
    logic        sw_rst_r;
    logic [2:0]  irq_en_r;
    logic [1:0]  spd_wr_r;
    logic        rx_tim_wr_r;
    logic        tx_tim_wr_r;
    logic [1:0]  spd_act_r;
    mfr_evt_t    status;
    mfr_evt_t    evt;

    assign rb.wr_hit = idx_mapped(rb.wr_idx);
    assign rb.rd_hit = idx_mapped(rb.rd_idx);
    assign wr_en_irq = rb.wr_req && rb.wr_idx == `MFR_IDX_IRQ_EN;
    assign wr_ctrl2  = rb.wr_req && rb.wr_idx == `MFR_IDX_CTRL2;
    assign wr_soft   = rb.wr_req && rb.wr_idx == `MFR_IDX_SOFT;
    assign rd_status = rb.rd_req && rb.rd_idx == `MFR_IDX_STATUS;
    assign evt       = {fifo_ovf_evt, fifo_idle_ins_evt, fifo_idle_del_evt};

    // ----------------------------------------------------------------
    // Software reset, one-cycle pulse
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            sw_rst_r <= 1'b0;
        else
            sw_rst_r <= wr_soft &&
                        wbit(rb.wr_data, rb.wr_strb, `MFR_B_SW_RST, 1'b0);
    end

    // ----------------------------------------------------------------
    // Interrupt enables, kept over software reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_r <= `MFR_RST_IRQ_EN;
        end else if (wr_en_irq) begin
            irq_en_r <= {wbit(rb.wr_data, rb.wr_strb, `MFR_B_FIFO_ERR,
                              irq_en_r[2]),
                         wbit(rb.wr_data, rb.wr_strb, `MFR_B_IDLE_INS,
                              irq_en_r[1]),
                         wbit(rb.wr_data, rb.wr_strb, `MFR_B_IDLE_DEL,
                              irq_en_r[0])};
        end
    end

    // ----------------------------------------------------------------
    // Latched FIFO status
    // ----------------------------------------------------------------
    mfr_evt_latch u_latch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sw_rst  (sw_rst_r),
        .evt     (evt),
        .rd_clr  (rd_status),
        .status  (status)
    );

    // ----------------------------------------------------------------
    // Control register two
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            line_loopback <= `MFR_RST_LINE_LB;
        else if (sw_rst_r)
            line_loopback <= `MFR_RST_LINE_LB;
        else if (wr_ctrl2)
            line_loopback <= wbit(rb.wr_data, rb.wr_strb, `MFR_B_LINE_LB,
                                  line_loopback);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_carrier_ext <= `MFR_RST_BCE;
        end else if (wr_ctrl2) begin
            block_carrier_ext <= wbit(rb.wr_data, rb.wr_strb, `MFR_B_BCE,
                                      block_carrier_ext);
        end
    end

    // Written values are shadowed until a software reset applies them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spd_wr_r    <= `MFR_RST_SPEED;
            rx_tim_wr_r <= `MFR_RST_RX_TIM;
            tx_tim_wr_r <= `MFR_RST_TX_TIM;
        end else if (wr_ctrl2) begin
            spd_wr_r    <= {wbit(rb.wr_data, rb.wr_strb, `MFR_B_SPD_MSB,
                                 spd_wr_r[1]),
                            wbit(rb.wr_data, rb.wr_strb, `MFR_B_SPD_LSB,
                                 spd_wr_r[0])};
            rx_tim_wr_r <= wbit(rb.wr_data, rb.wr_strb, `MFR_B_RX_TIM,
                                rx_tim_wr_r);
            tx_tim_wr_r <= wbit(rb.wr_data, rb.wr_strb, `MFR_B_TX_TIM,
                                tx_tim_wr_r);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spd_act_r     <= `MFR_RST_SPEED;
            rx_clk_centre <= `MFR_RST_RX_TIM;
            tx_clk_delay  <= `MFR_RST_TX_TIM;
        end else if (sw_rst_r) begin
            spd_act_r     <= spd_wr_r;
            rx_clk_centre <= rx_tim_wr_r;
            tx_clk_delay  <= tx_tim_wr_r;
        end
    end

    // ----------------------------------------------------------------
    // MAC interface speed
    // ----------------------------------------------------------------
    // Link down or MAC loopback takes the applied default speed, otherwise the link speed
    always_ff @(posedge aclk) begin
        if (!aresetn)
            mac_speed <= MFR_SPD_1000;
        else if (!link_up || mac_loopback)
            mac_speed <= spd_act_r;
        else
            mac_speed <= link_speed;
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(status & irq_en_r);
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        rb.rd_data = 16'h0000;
        case (rb.rd_idx)
            `MFR_IDX_IRQ_EN: begin
                rb.rd_data[`MFR_B_FIFO_ERR] = irq_en_r[2];
                rb.rd_data[`MFR_B_IDLE_INS] = irq_en_r[1];
                rb.rd_data[`MFR_B_IDLE_DEL] = irq_en_r[0];
            end
            `MFR_IDX_STATUS: begin
                rb.rd_data[`MFR_B_FIFO_ERR] = status[2];
                rb.rd_data[`MFR_B_IDLE_INS] = status[1];
                rb.rd_data[`MFR_B_IDLE_DEL] = status[0];
            end
            `MFR_IDX_CTRL2: begin
                rb.rd_data[`MFR_B_LINE_LB] = line_loopback;
                rb.rd_data[`MFR_B_SPD_LSB] = spd_wr_r[0];
                rb.rd_data[12:7]           = `MFR_CTRL2_RSV_HI;
                rb.rd_data[`MFR_B_SPD_MSB] = spd_wr_r[1];
                rb.rd_data[`MFR_B_RX_TIM]  = rx_tim_wr_r;
                rb.rd_data[`MFR_B_TX_TIM]  = tx_tim_wr_r;
                rb.rd_data[`MFR_B_BCE]     = block_carrier_ext;
                rb.rd_data[2:0]            = `MFR_CTRL2_RSV_LO;
            end
            default: begin
                rb.rd_data = 16'h0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_en_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en_irq && rb.wr_strb[0] |=>
            irq_en_r == {$past(rb.wr_data[7]), $past(rb.wr_data[3]),
                         $past(rb.wr_data[2])})
        else $error("interrupt enables not written");
    a_en_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> irq_en_r == 3'h0 && !irq)
        else $error("enables not zero after reset");
    a_status_rsv: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_status |-> rb.rd_data[15:8] == 8'h00 && rb.rd_data[6:4] == 3'h0 &&
                      rb.rd_data[1:0] == 2'h0)
        else $error("reserved status bits not zero");
    a_line_lb: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_rst_r |=> !line_loopback)
        else $error("line loopback not cleared by software reset");
    a_speed_down: assert property (@(posedge aclk) disable iff (!aresetn)
        !link_up && !sw_rst_r |=> mac_speed == $past(spd_act_r))
        else $error("link-down speed not taken from defaults");
    a_speed_lb: assert property (@(posedge aclk) disable iff (!aresetn)
        link_up && mac_loopback |=> mac_speed == $past(spd_act_r))
        else $error("loopback speed not taken from defaults");
    a_speed_up: assert property (@(posedge aclk) disable iff (!aresetn)
        link_up && !mac_loopback |=> mac_speed == $past(link_speed))
        else $error("link-up speed not followed");
    a_update_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        !sw_rst_r |=> $stable(spd_act_r) && $stable(rx_clk_centre) &&
                      $stable(tx_clk_delay))
        else $error("timing changed without software reset");
    a_update_take: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_rst_r |=> spd_act_r == $past(spd_wr_r) ##1
                     spd_wr_r == $past(spd_wr_r) || $past(wr_ctrl2))
        else $error("software reset did not apply speed");
    a_rx_timing: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_rst_r |=> rx_clk_centre == $past(rx_tim_wr_r))
        else $error("receive timing not applied");
    a_tx_timing: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_rst_r |=> tx_clk_delay == $past(tx_tim_wr_r))
        else $error("transmit timing not applied");
    a_bce_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl2 && rb.wr_strb[0] |=> block_carrier_ext == $past(rb.wr_data[3]))
        else $error("carrier extension bit not written");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 irq == |($past(status) & $past(irq_en_r)))
        else $error("interrupt level wrong");
    a_irq_mask: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (status & irq_en_r) == 3'h0 |=> !irq)
        else $error("disabled interrupt raised");
    a_en_keep: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !wr_en_irq |=> $stable(irq_en_r))
        else $error("interrupt enables changed without a write");
    a_rd_status: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_status |=> s_axi_rdata[7] == $past(status[2]) &&
                      s_axi_rdata[3] == $past(status[1]) &&
                      s_axi_rdata[2] == $past(status[0]))
        else $error("status read data wrong");
    a_lb_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_ctrl2 && rb.wr_strb[1] && !sw_rst_r |=>
            line_loopback == $past(rb.wr_data[14]))
        else $error("line loopback bit not written");
    a_spd_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !wr_ctrl2 |=> $stable(spd_wr_r) && $stable(rx_tim_wr_r) &&
                      $stable(tx_tim_wr_r))
        else $error("shadow speed or timing changed without a write");
    a_tim_reset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> rx_clk_centre && tx_clk_delay &&
                            spd_act_r == 2'h2 && !block_carrier_ext)
        else $error("control outputs wrong after reset");
    a_bce_keep: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !wr_ctrl2 |=> $stable(block_carrier_ext))
        else $error("carrier extension changed without a write");

endmodule

`default_nettype wire

/* File: mfr_mac_regs_test.sv */
`default_nettype none
module mfr_mac_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // Stimulus
    // ----------------
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0;
    logic        arv = 0, rre = 0, lup = 0, mlb = 0;
    logic        awr, wr, bv, arr, rv, llb, rxc, txd, bce, irq, o, i, d;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0]  br, rr, spd, lsp = 0;
    logic [2:0]  req = 0, ev, en;
    logic [3:0]  ws = 4'hF;
    int          seed = 32'h4ec9d02f, mismatches = 0, checked = 0, cyc = 0;
    mfr_fifo_peer u_mfr_fifo_peer (.aclk(aclk), .req(req), .ovf(o),
        .ins(i), .del(d));
    mfr_mac_regs u_mfr_mac_regs (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .fifo_ovf_evt(o),
        .fifo_idle_ins_evt(i), .fifo_idle_del_evt(d), .link_up(lup),
        .link_speed(lsp), .mac_loopback(mlb), .line_loopback(llb),
        .mac_speed(spd), .rx_clk_centre(rxc), .tx_clk_delay(txd),
        .block_carrier_ext(bce), .irq(irq));
    initial forever #12.5 aclk = ~aclk;
    function automatic logic [31:0] st(logic [2:0] e);
        return {24'h0, e[2], 3'b000, e[1], e[0], 2'b00};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrr(logic [7:0] a, logic [31:0] v, logic [1:0] e);
        @(posedge aclk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= v;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        bre <= 1'b0;
        chk("bresp", 32'(br), 32'(e));
    endtask
    task automatic rdr(logic [7:0] a, logic [31:0] e, logic [1:0] er);
        @(posedge aclk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        chk("rdata", rd, e);
        chk("rresp", 32'(rr), 32'(er));
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(8'h54, 32'h1076, 2'h0);
        rdr(8'h48, 32'h0, 2'h0);
        rdr(8'h4C, 32'h0, 2'h0);
        rdr(8'h50, 32'h0, 2'h3);
        chk("mac_speed", 32'(spd), 32'h2);
        repeat (8) begin
            ev = 3'($random(seed));
            en = 3'($random(seed));
            wrr(8'h48, st(en), 2'h0);
            req <= ev;
            @(posedge aclk);
            req <= 3'h0;
            repeat (4) @(posedge aclk);
            chk("irq", 32'(irq), 32'(|(ev & en)));
            rdr(8'h4C, st(ev), 2'h0);
            rdr(8'h4C, 32'h0, 2'h0);
            chk("irq_clr", 32'(irq), 32'h0);
        end
        req <= 3'h1;
        rdr(8'h4C, st(3'h1), 2'h0);
        rdr(8'h4C, st(3'h1), 2'h0);
        req <= 3'h0;
        rdr(8'h4C, st(3'h1), 2'h0);
        rdr(8'h4C, 32'h0, 2'h0);
        wrr(8'h4C, 32'hFFFF, 2'h0);
        rdr(8'h4C, 32'h0, 2'h0);
        wrr(8'h50, 32'hFFFF, 2'h3);
        wrr(8'h48, st(3'h7), 2'h0);
        ws <= 4'h2;
        wrr(8'h48, 32'h0, 2'h0);
        ws <= 4'hF;
        rdr(8'h48, 32'h8C, 2'h0);
        wrr(8'h54, 32'h6008, 2'h0);
        repeat (2) @(posedge aclk);
        chk("line_lb", 32'(llb), 32'h1);
        chk("mac_speed", 32'(spd), 32'h2);
        req <= 3'h7;
        @(posedge aclk);
        req <= 3'h0;
        wrr(8'h7C, 32'h1, 2'h0);
        repeat (3) @(posedge aclk);
        chk("irq_sw", 32'(irq), 32'h0);
        chk("mac_speed", 32'(spd), 32'h1);
        chk("rx_clk", 32'(rxc), 32'h0);
        chk("tx_clk", 32'(txd), 32'h0);
        chk("line_lb", 32'(llb), 32'h0);
        chk("bce", 32'(bce), 32'h1);
        rdr(8'h54, 32'h300E, 2'h0);
        rdr(8'h4C, 32'h0, 2'h0);
        lup <= 1'b1;
        lsp <= 2'($random(seed));
        repeat (3) @(posedge aclk);
        chk("link_spd", 32'(spd), 32'(lsp));
        lsp <= 2'h1;
        mlb <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("lb_spd", 32'(spd), 32'h1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(8'h54, 32'h1076, 2'h0);
        results();
    end
endmodule
`default_nettype wire

/* File: mfr_pkg.sv */
`default_nettype none

package mfr_pkg;

    // MAC interface speed codes
    typedef enum logic [1:0] {
        MFR_SPD_10   = 2'h0,
        MFR_SPD_100  = 2'h1,
        MFR_SPD_1000 = 2'h2
    } mfr_speed_t;

    // Latched event vector: {fifo error, idle inserted, idle deleted}
    typedef logic [2:0] mfr_evt_t;

endpackage

`default_nettype wire

/* File: mfr_reg_if.sv */
`default_nettype none

interface mfr_reg_if;
    logic        wr_req;
    logic [5:0]  wr_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_hit;
    logic        rd_req;
    logic [5:0]  rd_idx;
    logic [15:0] rd_data;
    logic        rd_hit;

    modport slave (
        output wr_req, wr_idx, wr_data, wr_strb, rd_req, rd_idx,
        input  wr_hit, rd_data, rd_hit
    );
    modport bank (
        input  wr_req, wr_idx, wr_data, wr_strb, rd_req, rd_idx,
        output wr_hit, rd_data, rd_hit
    );
endinterface

`default_nettype wire
